// [hdl/pets_params.svh]
// Offsets, field positions and reset values of the egress timestamp filter.
// Included by pets_qualify and pets_filter; definitions only.
`ifndef PETS_PARAMS_SVH
`define PETS_PARAMS_SVH
`define PETS_QUAL_CFG_OFS 12'h15c
`define PETS_MOD_CTL_OFS 12'h164
`define PETS_QUAL_CFG_RST 32'h0002_0000
`define PETS_MOD_CTL_RST 32'h0005_0000
`define PETS_MOD_CTL_WMASK 32'h303f_0000
`define PETS_DOM_HI 31
`define PETS_DOM_LO 24
`define PETS_DOM_EN_BIT 23
`define PETS_ALT_EN_BIT 22
`define PETS_UDP_BYP_BIT 21
`define PETS_FCS_BYP_BIT 20
`define PETS_VER_HI 19
`define PETS_VER_LO 16
`define PETS_MASK_HI 15
`define PETS_TA_INS_BIT 29
`define PETS_SYNC_INS_BIT 28
`define PETS_OFS_HI 21
`define PETS_OFS_LO 16
`define PETS_MSG_SYNC 4'h0
`define PETS_MSG_PDRESP 4'h3
`endif

// [hdl/pets_pkg.sv]
// Types shared by the egress timestamp filter modules.
// Assumes pets_params.svh is on the include path.
package pets_pkg;
  typedef struct packed {
    logic [7:0] domain;
    logic alt_flag;
    logic [3:0] version;
    logic [3:0] msg_type;
    logic fcs_ok;
    logic udp_ok;
  } pets_msg_t;

  typedef struct packed {
    logic [7:0] egress_domain_value;
    logic egress_domain_match_on;
    logic alt_primary_flag_check_on;
    logic udp_sum_check_bypass;
    logic frame_crc_check_bypass;
    logic [3:0] egress_protocol_version;
    logic [15:0] egress_msg_type_mask;
  } pets_qual_t;

  typedef enum logic [2:0] {
    PETS_IDLE = 3'b001,
    PETS_SETUP = 3'b010,
    PETS_ACCESS = 3'b100
  } pets_apb_st_t;
endpackage

// [hdl/pets_qualify.sv]
// Combinational qualification of one outgoing PTP message header.
// Assumes the caller registers the result and supplies frame status.
`timescale 1ns/1ps
`include "pets_params.svh"
module pets_qualify
  import pets_pkg::*;
(
  input wire pets_qual_t cfg, // Qualification settings
  input wire pets_msg_t msg, // Parsed message fields
  output logic pass // Every enabled check passed
);
  logic type_ok, ver_ok, dom_ok, alt_ok, fcs_ok, udp_ok;
  always_comb begin
    type_ok = cfg.egress_msg_type_mask[msg.msg_type];
    ver_ok = (cfg.egress_protocol_version == 4'h0) ||
             (cfg.egress_protocol_version == msg.version);
    dom_ok = !cfg.egress_domain_match_on ||
             (cfg.egress_domain_value == msg.domain);
    alt_ok = !cfg.alt_primary_flag_check_on || !msg.alt_flag;
    fcs_ok = cfg.frame_crc_check_bypass || msg.fcs_ok;
    udp_ok = cfg.udp_sum_check_bypass || msg.udp_ok;
    pass = type_ok && ver_ok && dom_ok && alt_ok && fcs_ok && udp_ok;
  end
endmodule // pets_qualify

// [hdl/pets_apb_slave.sv]
// APB slave handshake: one wait state, pready from a flip-flop.
// Assumes a well-behaved APB master on pclk.
`timescale 1ns/1ps
module pets_apb_slave
  import pets_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // Slave select
  input wire logic penable, // Access phase
  output logic pready, // Transfer completes
  output logic take // Pulse: commit access this cycle
);
  pets_apb_st_t st_reg, st_next;
  logic ready_reg, ready_next;
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PETS_IDLE: if (psel && !penable) st_next = PETS_SETUP;
      PETS_SETUP: st_next = PETS_ACCESS;
      PETS_ACCESS: st_next = PETS_IDLE;
      default: st_next = PETS_IDLE;
    endcase
    ready_next = (st_next == PETS_ACCESS);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= PETS_IDLE;
      ready_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ready_reg <= ready_next;
    end
  end
  // Ready rises in the second access cycle so read data can be registered first
  assign pready = ready_reg;
  assign take = (st_reg == PETS_SETUP) && psel && penable;
endmodule // pets_apb_slave

// [hdl/pets_filter.sv]
// Egress timestamp qualification and modification control, APB registers.
// Assumes message fields are valid with msg_valid from same-clock framer logic.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pets_params.svh"
module pets_filter
  import pets_pkg::*;
(
  input wire logic pclk, // 100 MHz clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // Unmapped address
  input wire logic msg_valid, // Pulse: header fields valid
  input wire pets_msg_t msg, // Header fields and frame status
  output logic ts_save, // Pulse: record egress time
  output logic [3:0] ts_msg_type, // Type of last message, recorded or not
  output logic insert_sync_time, // Pulse: write originTimestamp
  output logic insert_turnaround, // Pulse: write correction field
  output logic [5:0] spare_byte_offset // Header spare byte offset
);
  logic [31:0] cfg_reg, cfg_next, mod_reg, mod_next;
  logic [31:0] rd_reg, rd_next;
  logic err_reg, err_next;
  logic take, pass, cfg_hit, mod_hit;
  logic save_reg, save_next, sync_reg, sync_next, ta_reg, ta_next;
  logic [3:0] type_reg, type_next;
  pets_qual_t qcfg;

  pets_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .take(take)
  );

  assign qcfg = '{
    egress_domain_value: cfg_reg[`PETS_DOM_HI:`PETS_DOM_LO],
    egress_domain_match_on: cfg_reg[`PETS_DOM_EN_BIT],
    alt_primary_flag_check_on: cfg_reg[`PETS_ALT_EN_BIT],
    udp_sum_check_bypass: cfg_reg[`PETS_UDP_BYP_BIT],
    frame_crc_check_bypass: cfg_reg[`PETS_FCS_BYP_BIT],
    egress_protocol_version: cfg_reg[`PETS_VER_HI:`PETS_VER_LO],
    egress_msg_type_mask: cfg_reg[`PETS_MASK_HI:0]
  };

  pets_qualify u_qual (
    .cfg(qcfg),
    .msg(msg),
    .pass(pass)
  );

  // Registers
  always_comb begin
    cfg_hit = (paddr == `PETS_QUAL_CFG_OFS);
    mod_hit = (paddr == `PETS_MOD_CTL_OFS);
    cfg_next = cfg_reg;
    mod_next = mod_reg;
    rd_next = rd_reg;
    // Error flop is high only in the cycle that pready is high
    err_next = 1'b0;
    if (take) begin
      err_next = !(cfg_hit || mod_hit);
      rd_next = 32'h0000_0000;
      if (pwrite) begin
        if (cfg_hit) cfg_next = pwdata;
        if (mod_hit) begin
          mod_next = pwdata & `PETS_MOD_CTL_WMASK;
        end
      end else if (cfg_hit) begin
        rd_next = cfg_reg;
      end else if (mod_hit) begin
        rd_next = mod_reg;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `PETS_QUAL_CFG_RST;
      mod_reg <= `PETS_MOD_CTL_RST;
      rd_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      mod_reg <= mod_next;
      rd_reg <= rd_next;
      err_reg <= err_next;
    end
  end
  assign prdata = rd_reg;
  assign pslverr = err_reg;
  assign spare_byte_offset = mod_reg[`PETS_OFS_HI:`PETS_OFS_LO];

  // Per-message decisions, one cycle after msg_valid
  always_comb begin
    save_next = msg_valid && pass;
    type_next = msg_valid ? msg.msg_type : type_reg;
    // Insertion acts on host frames regardless of the save decision
    sync_next = msg_valid && mod_reg[`PETS_SYNC_INS_BIT] &&
                (msg.msg_type == `PETS_MSG_SYNC);
    ta_next = msg_valid && mod_reg[`PETS_TA_INS_BIT] &&
              (msg.msg_type == `PETS_MSG_PDRESP);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_reg <= 1'b0;
      type_reg <= 4'h0;
      sync_reg <= 1'b0;
      ta_reg <= 1'b0;
    end else begin
      save_reg <= save_next;
      type_reg <= type_next;
      sync_reg <= sync_next;
      ta_reg <= ta_next;
    end
  end
  assign ts_save = save_reg;
  assign ts_msg_type = type_reg;
  assign insert_sync_time = sync_reg;
  assign insert_turnaround = ta_reg;

  chk_domain_gate: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && cfg_reg[`PETS_DOM_EN_BIT] &&
    msg.domain != cfg_reg[`PETS_DOM_HI:`PETS_DOM_LO] |=> !ts_save)
    else $error("Saved with mismatched domain");
  chk_domain_off: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !cfg_reg[`PETS_DOM_EN_BIT] && msg.fcs_ok && msg.udp_ok &&
    !msg.alt_flag && cfg_reg[msg.msg_type] &&
    cfg_reg[`PETS_VER_HI:`PETS_VER_LO] == 4'h0 |=> ts_save)
    else $error("Domain compared while disabled");
  chk_alt_flag: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && cfg_reg[`PETS_ALT_EN_BIT] && msg.alt_flag |=> !ts_save)
    else $error("Saved with alternate flag set");
  chk_udp_block: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !cfg_reg[`PETS_UDP_BYP_BIT] && !msg.udp_ok |=> !ts_save)
    else $error("Saved with bad UDP checksum");
  chk_fcs_block: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !cfg_reg[`PETS_FCS_BYP_BIT] && !msg.fcs_ok |=> !ts_save)
    else $error("Saved with bad FCS");
  chk_version: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && cfg_reg[`PETS_VER_HI:`PETS_VER_LO] != 4'h0 &&
    cfg_reg[`PETS_VER_HI:`PETS_VER_LO] != msg.version |=> !ts_save)
    else $error("Saved with wrong version");
  chk_type_mask: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !cfg_reg[msg.msg_type] |=> !ts_save)
    else $error("Saved with type disabled");
  chk_save_cause: assert property (@(posedge pclk) disable iff (!presetn)
    ts_save |-> $past(msg_valid) && ts_msg_type == $past(msg.msg_type))
    else $error("Save without qualified message");
  chk_sync_ins: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && mod_reg[`PETS_SYNC_INS_BIT] && msg.msg_type == 4'h0
    |=> insert_sync_time ##1 !insert_sync_time || $past(msg_valid))
    else $error("Sync insertion missed");
  chk_ta_ins: assert property (@(posedge pclk) disable iff (!presetn)
    insert_turnaround |-> $past(mod_reg[`PETS_TA_INS_BIT]) && ts_msg_type == 4'h3)
    else $error("Turnaround insertion without cause");
  chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (mod_reg & ~`PETS_MOD_CTL_WMASK) == 32'h0000_0000)
    else $error("Reserved modify bits set");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable ##1 psel && penable |=> pready)
    else $error("APB ready late");
endmodule // pets_filter

// [test/pets_frame_src.sv]
// Far-side model: outgoing frame parser that presents one PTP header per call.
// Assumes pclk from the bench; between frames the header lines show junk.
`timescale 1ns/1ps
module pets_frame_src
  import pets_pkg::*;
(
  input wire logic pclk, // Device clock
  output logic msg_valid, // Pulse: header fields valid
  output pets_msg_t msg // Header fields and frame status
);
  initial begin
    msg_valid = 1'b0;
    msg = '0;
  end

  // Idle fields invert, so a design that samples outside the pulse is caught
  task automatic send(input pets_msg_t m);
    @(posedge pclk);
    msg_valid <= 1'b1;
    msg <= m;
    @(posedge pclk);
    msg_valid <= 1'b0;
    msg <= ~m;
  endtask
endmodule // pets_frame_src

// [test/test_ptp_egress_timestamp_filter.sv]
// Self-checking bench for the egress timestamp filter and its APB registers.
// Assumes pets_pkg and pets_frame_src are compiled first.
`timescale 1ns/1ps
module test_ptp_egress_timestamp_filter;
  import pets_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, msg_valid, ts_save, insert_sync_time, insert_turnaround;
  pets_msg_t msg;
  logic [3:0] ts_msg_type;
  logic [5:0] spare_byte_offset;
  logic [31:0] mod_now = 32'h0005_0000;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  pets_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .msg_valid(msg_valid), .msg(msg), .ts_save(ts_save),
    .ts_msg_type(ts_msg_type), .insert_sync_time(insert_sync_time),
    .insert_turnaround(insert_turnaround), .spare_byte_offset(spare_byte_offset));
  pets_frame_src src (.pclk(pclk), .msg_valid(msg_valid), .msg(msg));

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the fewer than one hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask

  task automatic send_chk(input logic [7:0] dm, input logic al, input logic [3:0] vr,
                          input logic [3:0] ty, input logic fc, input logic ud,
                          input logic exp);
    pets_msg_t m;
    m.domain = dm;
    m.alt_flag = al;
    m.version = vr;
    m.msg_type = ty;
    m.fcs_ok = fc;
    m.udp_ok = ud;
    src.send(m);
    #1;
    chk("ts_save", {31'h0, exp}, {31'h0, ts_save});
    chk("ts_msg_type", {28'h0, ty}, {28'h0, ts_msg_type});
    chk("insert_sync_time", {31'h0, ty == 4'h0 && mod_now[28]}, {31'h0, insert_sync_time});
    chk("insert_turnaround", {31'h0, ty == 4'h3 && mod_now[29]}, {31'h0, insert_turnaround});
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("spare_byte_offset", 32'h5, {26'h0, spare_byte_offset});
    rd_chk("qual_cfg reset", 12'h15c, 32'h0002_0000, 1'b0);
    rd_chk("mod_ctl reset", 12'h164, 32'h0005_0000, 1'b0);
    apb(1'b1, 12'h160, 32'hffff_ffff);
    rd_chk("unmapped read", 12'h160, 32'h0, 1'b1);
    send_chk(8'h00, 1'b0, 4'h2, 4'h0, 1'b1, 1'b1, 1'b0);
    apb(1'b1, 12'h164, 32'hffff_ffff);
    mod_now = 32'h303f_0000;
    rd_chk("mod_ctl masked", 12'h164, 32'h303f_0000, 1'b0);
    chk("spare_byte_offset", 32'h3f, {26'h0, spare_byte_offset});
    // Config is written while timestamping is idle; four event types on
    apb(1'b1, 12'h15c, 32'h12c2_000f);
    rd_chk("qual_cfg", 12'h15c, 32'h12c2_000f, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h0, 1'b1, 1'b1, 1'b1);
    send_chk(8'h13, 1'b0, 4'h2, 4'h0, 1'b1, 1'b1, 1'b0);
    send_chk(8'h12, 1'b1, 4'h2, 4'h1, 1'b1, 1'b1, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h2, 1'b1, 1'b0, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h3, 1'b0, 1'b1, 1'b0);
    send_chk(8'h12, 1'b0, 4'h1, 4'h1, 1'b1, 1'b1, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h4, 1'b1, 1'b1, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h3, 1'b1, 1'b1, 1'b1);
    apb(1'b1, 12'h164, 32'h0000_0000);
    mod_now = 32'h0000_0000;
    apb(1'b1, 12'h15c, 32'h1230_0010);
    send_chk(8'h55, 1'b1, 4'h7, 4'h4, 1'b0, 1'b0, 1'b1);
    send_chk(8'h99, 1'b0, 4'h3, 4'h4, 1'b1, 1'b1, 1'b1);
    send_chk(8'h55, 1'b1, 4'h7, 4'h0, 1'b1, 1'b1, 1'b0);
    send_chk(8'h12, 1'b0, 4'h2, 4'h3, 1'b1, 1'b1, 1'b0);
    results();
  end
endmodule // test_ptp_egress_timestamp_filter
